// ===== src/amfc_consts.svh
`ifndef AMFC_CONSTS_SVH
`define AMFC_CONSTS_SVH
`define AMFC_ADDR_W 16
`define AMFC_OFF_SLOT10 16'h2100
`define AMFC_OFF_SLOT8_9 16'h2101
`define AMFC_OFF_SLOT6_7 16'h2102
`define AMFC_OFF_SLOT4_5 16'h2103
`define AMFC_OFF_SLOT2_3 16'h2104
`define AMFC_OFF_SLOT0_1 16'h2105
`define AMFC_OFF_DIFF_DEC 16'h210c
`define AMFC_OFF_CLK_RATE 16'h2200
`define AMFC_OFF_PREAMP 16'h2704
`define AMFC_OFF_REMOTE 16'h2709
`define AMFC_RESET_VAL 8'h00
`define AMFC_NUM_SLOTS 11
`define AMFC_MAX_SLOTS 4'hb
`define AMFC_SLOT_CNT_MSB 7
`define AMFC_SLOT_CNT_LSB 4
`define AMFC_ADC_RATE_BIT 5
`define AMFC_PLL_FAST_BIT 4
`define AMFC_DEC_MSB 2
`define AMFC_DEC_LSB 1
`define AMFC_DIFF_LSB 4
`define AMFC_DIFF_MSB 7
`define AMFC_PREAMP_BIT 5
`define AMFC_REMOTE_LSB 3
`define AMFC_REMOTE_MSB 5
`define AMFC_SLOT0_BYTE 4'h5
`define AMFC_SETTLE_SLOW 8'h03
`define AMFC_SETTLE_FAST 8'h01
`endif

// ===== src/amfc_pkg.sv
package amfc_pkg;
    typedef enum logic [1:0] {AMFC_IDLE, AMFC_SLOT, AMFC_SETTLE} amfc_state_t;
    typedef logic [3:0] amfc_sel_t;
endpackage : amfc_pkg

// ===== src/amfc_regs_if.sv
interface amfc_regs_if;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [87:0] cfg;
    modport owner (input wr, input addr, input wdata, output rdata, output cfg);
    modport user (output wr, output addr, output wdata, input rdata, input cfg);
endinterface : amfc_regs_if

// ===== src/amfc_regs.sv
`include "amfc_consts.svh"
module amfc_regs
(
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    amfc_regs_if.owner rb
);
    logic [7:0] r_q [0:9];
    logic [15:0] offs [0:9];
    assign offs[0] = `AMFC_OFF_SLOT10;
    assign offs[1] = `AMFC_OFF_SLOT8_9;
    assign offs[2] = `AMFC_OFF_SLOT6_7;
    assign offs[3] = `AMFC_OFF_SLOT4_5;
    assign offs[4] = `AMFC_OFF_SLOT2_3;
    assign offs[5] = `AMFC_OFF_SLOT0_1;
    assign offs[6] = `AMFC_OFF_DIFF_DEC;
    assign offs[7] = `AMFC_OFF_CLK_RATE;
    assign offs[8] = `AMFC_OFF_PREAMP;
    assign offs[9] = `AMFC_OFF_REMOTE;
    logic [7:0] rd_d;
    always_comb
    begin
        rd_d = 8'h00;
        for (int i = 0; i < 10; i++)
        begin
            if (rb.addr == offs[i])
            begin
                rd_d = r_q[i];
            end
        end
    end
    genvar g;
    generate
        for (g = 0; g < 10; g++)
        begin : g_reg
            // all fields clear on reset and stay read/write
            always_ff @(posedge sys_clk_in)
            begin
                if (!rst_n_in)
                    r_q[g] <= `AMFC_RESET_VAL;
                else if (rb.wr && rb.addr == offs[g])
                    r_q[g] <= rb.wdata;
            end
            assign rb.cfg[g*8 +: 8] = r_q[g];
        end
    endgenerate
    // spare top byte of the bus; only ten registers exist
    assign rb.cfg[87:80] = 8'h00;
    // read data registered so the top's read port is a flop
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
            rb.rdata <= 8'h00;
        else
            rb.rdata <= rd_d;
    end
endmodule : amfc_regs

// ===== src/amfc_frame_ctrl.sv
`include "amfc_consts.svh"
module amfc_frame_ctrl
    import amfc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // slow clock, synchronous to sys_clk_in
    input wire logic slow_32k_clock_in,
    // register port
    input wire logic reg_wr_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    // converter control
    output logic [3:0] slot_input_select_out,
    output logic [3:0] slot_index_out,
    output logic conv_active_out,
    output logic conv_start_out,
    output logic frame_sync_out,
    output logic [1:0] decimation_length_out,
    output logic adc_rate_out,
    output logic pll_fast_out,
    output logic low_bias_out,
    // front-end configuration
    output logic [3:0] diff_pair_enable_out,
    output logic [2:0] remote_sensor_enable_out,
    output logic preamp_enable_out,
    output logic preamp_gain8_out
);
    ////////////////////////////////////////////////////////////////////
    amfc_regs_if rb ();
    assign rb.wr = reg_wr_in;
    assign rb.addr = reg_addr_in;
    assign rb.wdata = reg_wdata_in;
    amfc_regs u_regs
    (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .rb(rb)
    );
    assign reg_rdata_out = rb.rdata;
    ////////////////////////////////////////////////////////////////////
    wire [7:0] r_slot10 = rb.cfg[7:0];
    wire [7:0] r_diff = rb.cfg[55:48];
    wire [7:0] r_clk = rb.cfg[63:56];
    wire [7:0] r_pre = rb.cfg[71:64];
    wire [7:0] r_rmt = rb.cfg[79:72];
    wire [3:0] slot_cnt = r_slot10[`AMFC_SLOT_CNT_MSB:`AMFC_SLOT_CNT_LSB];
    wire [3:0] slot_lim = (slot_cnt > `AMFC_MAX_SLOTS) ? `AMFC_MAX_SLOTS : slot_cnt;
    wire adc_rate = r_clk[`AMFC_ADC_RATE_BIT];
    wire pll_fast = r_clk[`AMFC_PLL_FAST_BIT];
    wire [1:0] dec_len = r_diff[`AMFC_DEC_MSB:`AMFC_DEC_LSB];
    // selector of slot n: slot 0 low nibble of 0x2105, slot 10 low nibble of 0x2100
    function automatic amfc_sel_t sel_of(input logic [87:0] cfg, input logic [3:0] n);
        logic [3:0] byte_i;
        byte_i = `AMFC_SLOT0_BYTE - n[3:1];
        sel_of = n[0] ? cfg[byte_i*8 + 4 +: 4] : cfg[byte_i*8 +: 4];
    endfunction : sel_of
    // slot length in slow cycles = (3-2*pll_fast)*(dec+1)*(rate+1); the same
    // 3-2*pll_fast term is the settle count, so one wire serves both
    wire [7:0] settle_len = pll_fast ? `AMFC_SETTLE_FAST : `AMFC_SETTLE_SLOW;
    wire [7:0] dec_mul = {6'h00, dec_len} + 8'h01;
    wire [7:0] rate_mul = {7'h00, adc_rate} + 8'h01;
    wire [7:0] slot_len = settle_len * dec_mul * rate_mul;
    ////////////////////////////////////////////////////////////////////
    // slow clock is sampled; edge detect on a registered copy
    // copy resets high: a clock already high at release must not count as a rise
    logic slow_q;
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
            slow_q <= 1'b1;
        else
            slow_q <= slow_32k_clock_in;
    end
    wire slow_rise = slow_32k_clock_in && !slow_q;
    amfc_state_t state_q, state_d;
    logic [3:0] slot_q, slot_d;
    logic [7:0] cnt_q, cnt_d;
    wire cnt_done = (cnt_q == 8'h01);
    wire last_slot = ((slot_q + 4'h1) >= slot_lim);
    always_comb
    begin
        state_d = state_q;
        slot_d = slot_q;
        cnt_d = cnt_q;
        case (state_q)
            AMFC_IDLE:
            begin
                // a zero slot count parks the sequencer for safe reconfiguration
                if (slow_rise && slot_lim != 4'h0)
                begin
                    state_d = AMFC_SLOT;
                    slot_d = 4'h0;
                    cnt_d = slot_len;
                end
            end
            AMFC_SLOT:
            begin
                if (slow_rise)
                begin
                    if (!cnt_done)
                        cnt_d = cnt_q - 8'h01;
                    else if (last_slot)
                    begin
                        state_d = AMFC_SETTLE;
                        cnt_d = settle_len;
                    end
                    else
                    begin
                        slot_d = slot_q + 4'h1;
                        cnt_d = slot_len;
                    end
                end
            end
            AMFC_SETTLE:
            begin
                if (slow_rise)
                begin
                    if (!cnt_done)
                        cnt_d = cnt_q - 8'h01;
                    else if (slot_lim == 4'h0)
                        state_d = AMFC_IDLE;
                    else
                    begin
                        state_d = AMFC_SLOT;
                        slot_d = 4'h0;
                        cnt_d = slot_len;
                    end
                end
            end
            default:
            begin
                state_d = AMFC_IDLE;
            end
        endcase
    end
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            state_q <= AMFC_IDLE;
            slot_q <= 4'h0;
            cnt_q <= 8'h00;
        end
        else
        begin
            state_q <= state_d;
            slot_q <= slot_d;
            cnt_q <= cnt_d;
        end
    end
    wire in_slot_d = (state_d == AMFC_SLOT);
    wire in_settle_d = (state_d == AMFC_SETTLE);
    wire starting = in_slot_d && (state_q != AMFC_SLOT || slot_d != slot_q
                    || (cnt_done && slow_rise));
    wire [3:0] diff_en = r_diff[`AMFC_DIFF_MSB:`AMFC_DIFF_LSB];
    wire [2:0] rmt_en = r_rmt[`AMFC_REMOTE_MSB:`AMFC_REMOTE_LSB];
    wire pre_en = r_pre[`AMFC_PREAMP_BIT];
    ////////////////////////////////////////////////////////////////////
    // sequencer view, launched from next state so pins line up with the state
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            slot_input_select_out <= 4'h0;
            slot_index_out <= 4'h0;
            conv_active_out <= 1'b0;
            conv_start_out <= 1'b0;
            frame_sync_out <= 1'b0;
        end
        else
        begin
            slot_input_select_out <= sel_of(rb.cfg, slot_d);
            slot_index_out <= slot_d;
            conv_active_out <= in_slot_d;
            conv_start_out <= starting;
            frame_sync_out <= in_settle_d;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // config copies, one flop each so every pin is a clean register
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            decimation_length_out <= 2'b00;
            adc_rate_out <= 1'b0;
            pll_fast_out <= 1'b0;
            low_bias_out <= 1'b0;
            diff_pair_enable_out <= 4'h0;
            remote_sensor_enable_out <= 3'b000;
            preamp_enable_out <= 1'b0;
            preamp_gain8_out <= 1'b0;
        end
        else
        begin
            decimation_length_out <= dec_len;
            adc_rate_out <= adc_rate;
            pll_fast_out <= pll_fast;
            low_bias_out <= adc_rate;
            diff_pair_enable_out <= diff_en;
            remote_sensor_enable_out <= rmt_en;
            // amplifier powered only when gain 8 is wanted
            preamp_enable_out <= pre_en;
            preamp_gain8_out <= pre_en;
        end
    end
endmodule : amfc_frame_ctrl

// ===== dv/amfc_frame_ctrl_assertions.sv
module amfc_frame_ctrl_assertions
(
    // clocks and register port
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic slow_32k_clock_in,
    input wire logic reg_wr_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    // watched outputs
    input wire logic [3:0] slot_index_out,
    input wire logic conv_active_out,
    input wire logic conv_start_out,
    input wire logic frame_sync_out,
    input wire logic [1:0] decimation_length_out,
    input wire logic adc_rate_out,
    input wire logic pll_fast_out,
    input wire logic low_bias_out,
    input wire logic [3:0] diff_pair_enable_out,
    input wire logic [2:0] remote_sensor_enable_out,
    input wire logic preamp_enable_out,
    input wire logic preamp_gain8_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic slow_q;
    logic cnt_wr_q;
    logic [2:0] since_q;
    logic [3:0] cnt_q;
    logic [7:0] wd1_q;
    logic [7:0] wd2_q;
    // shadow count lags a write by one edge, as the sequencer's own decode does
    wire cnt_wr = reg_wr_in && reg_addr_in == 16'h2100;
    wire slow_rise = slow_32k_clock_in && !slow_q;
    wire [3:0] lim = (cnt_q > 4'hb) ? 4'hb : cnt_q;
    always_ff @(posedge sys_clk_in)
    begin
        slow_q <= slow_32k_clock_in;
        wd1_q <= reg_wdata_in;
        wd2_q <= wd1_q;
        since_q <= slow_rise ? 3'h0 : since_q + {2'h0, since_q != 3'h7};
        cnt_wr_q <= !rst_n_in ? 1'b0 : cnt_wr;
        cnt_q <= !rst_n_in ? 4'h0 : (cnt_wr_q ? wd1_q[7:4] : cnt_q);
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    sequence s_wr(logic [15:0] a);
        reg_wr_in && reg_addr_in == a;
    endsequence
    sequence s_frame_end;
        $fell(frame_sync_out) && cnt_q != 4'h0;
    endsequence
    property p_start_edge;
        conv_start_out |-> conv_active_out && since_q <= 3'h2;
    endproperty
    a_start_edge: assert property (p_start_edge) else $error("slot start off slow edge");
    property p_wrap;
        s_frame_end |-> ##[0:2] (conv_start_out && slot_index_out == 4'h0);
    endproperty
    a_wrap: assert property (p_wrap) else $error("no slot 0 after settle");
    property p_slot_limit;
        conv_start_out |-> slot_index_out < lim;
    endproperty
    a_slot_limit: assert property (p_slot_limit) else $error("slot beyond count");
    property p_diff;
        s_wr(16'h210c) |-> ##2 diff_pair_enable_out == wd2_q[7:4]
            && decimation_length_out == wd2_q[2:1];
    endproperty
    a_diff: assert property (p_diff) else $error("diff or decimation copy wrong");
    property p_rate;
        s_wr(16'h2200) |-> ##2 adc_rate_out == wd2_q[5] && pll_fast_out == wd2_q[4]
            && low_bias_out == wd2_q[5];
    endproperty
    a_rate: assert property (p_rate) else $error("rate bits copy wrong");
    property p_remote;
        s_wr(16'h2709) |-> ##2 remote_sensor_enable_out == wd2_q[5:3];
    endproperty
    a_remote: assert property (p_remote) else $error("remote enables wrong");
    property p_preamp;
        s_wr(16'h2704) |-> ##2 preamp_enable_out == wd2_q[5];
    endproperty
    a_preamp: assert property (p_preamp) else $error("preamp enable wrong");
    property p_gain;
        preamp_gain8_out == preamp_enable_out;
    endproperty
    a_gain: assert property (p_gain) else $error("gain and power differ");
endmodule : amfc_frame_ctrl_assertions

bind amfc_frame_ctrl amfc_frame_ctrl_assertions u_chk (.*);

// ===== dv/amfc_front_end_model.sv
module amfc_front_end_model
#(
    parameter int SLOW_DIV = 8
)
(
    input wire logic sys_clk_in,
    input wire logic conv_start_in,
    input wire logic [3:0] sel_in,
    input wire logic [3:0] idx_in,
    output logic slow_32k_clock_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int ph = 0;
    int rises = 0;
    int n = 0;
    logic [3:0] sel_log[256];
    logic [3:0] idx_log[256];
    int rise_log[256];
    // slow clock runs free, shortened to SLOW_DIV system cycles to keep runs short
    always @(posedge sys_clk_in)
    begin
        ph <= (ph + 1) % SLOW_DIV;
        slow_32k_clock_out <= ph < SLOW_DIV / 2;
        if (ph == 0)
            rises <= rises + 1;
        if (conv_start_in && n < 256)
        begin
            sel_log[n] <= sel_in;
            idx_log[n] <= idx_in;
            rise_log[n] <= rises;
            n <= n + 1;
        end
    end
endmodule : amfc_front_end_model

// ===== dv/amfc_frame_ctrl_tb.sv
`include "amfc_consts.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module amfc_frame_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic slow_32k_clock_in;
    logic reg_wr_in = 1'b0;
    logic [15:0] reg_addr_in = 16'h0000;
    logic [7:0] reg_wdata_in = 8'h00;
    logic [7:0] reg_rdata_out;
    logic [3:0] slot_input_select_out, slot_index_out, diff_pair_enable_out;
    logic conv_active_out, conv_start_out, frame_sync_out, adc_rate_out, pll_fast_out;
    logic low_bias_out, preamp_enable_out, preamp_gain8_out;
    logic [1:0] decimation_length_out;
    logic [2:0] remote_sensor_enable_out;
    int errors = 0;
    int n_tests = 0;
    logic [15:0] regs[10] = '{16'h2100, 16'h2101, 16'h2102, 16'h2103, 16'h2104,
        16'h2105, 16'h210c, 16'h2200, 16'h2704, 16'h2709};
    // voltages 8..10 sit in slots 3..5, each ahead of its usual slot
    logic [7:0] vals[10] = '{8'h0a, 8'h98, 8'h76, 8'ha9, 8'h82,
        8'h10, 8'ha4, 8'h30, 8'h20, 8'h38};
    logic [3:0] exp_sel[11];
    amfc_frame_ctrl dut (.*);
    amfc_front_end_model m (.sys_clk_in(sys_clk_in), .conv_start_in(conv_start_out),
        .sel_in(slot_input_select_out), .idx_in(slot_index_out),
        .slow_32k_clock_out(slow_32k_clock_in));
    initial forever #4 sys_clk_in = ~sys_clk_in;
    ////////////////////////////////////////////////////////////////////////////
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        @(posedge sys_clk_in);
        #1;
        `CHK("rdata", e, reg_rdata_out)
    endtask : rd_chk
    // skips to the second slot 0 so the frame checked saw only the new settings
    task automatic frame_chk(input int cnt, input int len);
        int b, k, w;
        b = m.n;
        w = 0;
        while (m.n < b + 3 * cnt + 2 && w < 5000)
        begin
            @(posedge sys_clk_in);
            w++;
        end
        `CHK("frame wait", 1'b1, w < 5000)
        k = b + 1;
        while (k < 250 && m.idx_log[k] !== 4'h0) k++;
        k++;
        while (k < 250 && m.idx_log[k] !== 4'h0) k++;
        for (int i = 0; i < cnt; i++)
        begin
            `CHK("slot sel", exp_sel[i], m.sel_log[k + i])
            `CHK("slot idx", 4'(i), m.idx_log[k + i])
        end
        `CHK("frame len", len, m.rise_log[k + cnt] - m.rise_log[k])
    endtask : frame_chk
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge sys_clk_in);
        errors++;
        complete_run();
    end
    initial
    begin
        repeat (12) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        foreach (regs[i]) rd_chk(regs[i], 8'h00);
        rd_chk(16'h2106, 8'h00);
        $display("test reset values done");
        foreach (regs[i]) wr_reg(regs[i], vals[i]);
        wr_reg(16'h2106, 8'hff);
        foreach (regs[i]) rd_chk(regs[i], vals[i]);
        rd_chk(16'h2106, 8'h00);
        `CHK("diff", 4'ha, diff_pair_enable_out)
        `CHK("dec", 2'h2, decimation_length_out)
        `CHK("rate", 3'h7, {adc_rate_out, pll_fast_out, low_bias_out})
        `CHK("remote", 3'h7, remote_sensor_enable_out)
        `CHK("preamp", 2'h3, {preamp_enable_out, preamp_gain8_out})
        `CHK("idle", 1'b0, conv_active_out)
        $display("test register access done");
        wr_reg(16'h2200, 8'h10);
        wr_reg(16'h210c, 8'hb0);
        rd_chk(16'h2200, 8'h10);
        `CHK("bias", 2'h0, {adc_rate_out, low_bias_out})
        exp_sel = '{4'h0, 4'h1, 4'h2, 4'h8, 4'h9, 4'ha, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha};
        wr_reg(16'h2100, 8'h6a);
        frame_chk(6, 7);
        $display("test six slot frame done");
        // count above eleven is clamped, long settle with slow pll
        wr_reg(16'h2200, 8'h00);
        wr_reg(16'h2100, 8'hfa);
        frame_chk(11, 36);
        $display("test eleven slot frame done");
        // rate bit doubles and decimation two triples each slot; count lowered mid-run
        wr_reg(16'h2200, 8'h30);
        wr_reg(16'h210c, 8'hb4);
        wr_reg(16'h2100, 8'h2a);
        frame_chk(2, 13);
        $display("test rate and decimation frame done");
        complete_run();
    end
endmodule : amfc_frame_ctrl_tb
